// ===== asp_port.sv
// Async serial port core: AXI4-Lite registers, transmitter and receiver.
// Assumes serial_in_pin is already synchronous to aclk.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Notes on behaviour
// - Only one transmit and one receive pin
// - Power-off bit gives an idle low-power mode
// - Seven or eight data bits selectable
// - Five-bit divisor sets the bit rate
// - Transmit and receive have separate enables
// - Four base clock sources selectable
// - Data always least significant bit first
// - Runs normally while its clock runs
// - Clock stop freezes state and output pin
// - Enables synchronised to base clock ticks
// - Parity none, zero, odd or even
// - Power-off resets status, shift and buffer; the receive shift register rxs keeps its value
// - Seven-bit receive reads zero in bit seven
// - One or two transmitted stop bits
module asp_port
   import asp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_in_pin,
   output logic serial_out_pin
);
   typedef struct packed {
      logic pwr, txe, rxe;
      logic [1:0] par;
      logic cl, sl;
      logic [1:0] sel;
      logic [4:0] div;
      logic txe_m, txe_s, rxe_m, rxe_s;
      asp_tx_t tx_st;
      logic [7:0] txs;
      logic [3:0] tx_n;
      logic [4:0] tx_t;
      logic tx_p, tx_out;
      asp_rx_t rx_st;
      logic [7:0] rxs;
      logic [3:0] rx_n;
      logic [4:0] rx_t;
      logic rx_p;
      logic [7:0] rxb;
      logic rx_full, e_ovr, e_frm, e_par;
      logic awready, wready, aw_ok, w_ok;
      logic [7:0] awaddr, wbyte;
      logic wen, bvalid, arready, rvalid;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
   } asp_state_t;

   asp_state_t q_r;
   asp_state_t q_nxt;
   logic rx_line;
   logic tick;
   logic store_evt;
   asp_brg_if brg ();

   // Divisor below two gives no mid-bit sample point
   function automatic logic [4:0] bit_len(input logic [4:0] d);
      bit_len = (d < DIV_MIN) ? DIV_MIN : d;
   endfunction : bit_len

   function automatic logic [3:0] data_bits(input logic cl);
      data_bits = cl ? DBITS_8 : DBITS_7;
   endfunction : data_bits

   asp_brg u_brg (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .brg(brg)
   );
   assign brg.run = q_r.pwr;
   assign brg.sel = q_r.sel;
   assign tick = brg.base_tick;
   assign rx_line = q_r.pwr ? serial_in_pin : 1'b1;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      q_nxt = q_r;
      store_evt = 1'b0;
      // Bus write: address and data taken in either order
      if (s_axi_awvalid && q_r.awready)
      begin
         q_nxt.aw_ok = 1'b1;
         q_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q_r.wready)
      begin
         q_nxt.w_ok = 1'b1;
         q_nxt.wbyte = s_axi_wdata[7:0];
         q_nxt.wen = s_axi_wstrb[0];
      end
      if (q_r.bvalid && s_axi_bready)
      begin
         q_nxt.bvalid = 1'b0;
      end
      if (q_r.aw_ok && q_r.w_ok && !q_r.bvalid)
      begin
         q_nxt.aw_ok = 1'b0;
         q_nxt.w_ok = 1'b0;
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp = RESP_OKAY;
         case (q_r.awaddr)
            ADDR_CTRL:
            begin
               if (q_r.wen)
               begin
                  q_nxt.pwr = q_r.wbyte[CTRL_PWR];
                  q_nxt.txe = q_r.wbyte[CTRL_TXE];
                  q_nxt.rxe = q_r.wbyte[CTRL_RXE];
                  q_nxt.par = q_r.wbyte[CTRL_PAR_LO +: 2];
                  q_nxt.cl = q_r.wbyte[CTRL_CL];
                  q_nxt.sl = q_r.wbyte[CTRL_SL];
               end
            end
            ADDR_BRG:
            begin
               if (q_r.wen)
               begin
                  q_nxt.sel = q_r.wbyte[BRG_SEL_LO +: 2];
                  q_nxt.div = q_r.wbyte[4:0];
               end
            end
            ADDR_TXD:
            begin
               // Busy or disabled transmitter ignores the byte
               if (q_r.wen && q_r.txe_s && q_r.tx_st == TX_IDLE)
               begin
                  q_nxt.txs = q_r.wbyte;
                  q_nxt.tx_st = TX_START;
                  q_nxt.tx_out = 1'b0;
                  q_nxt.tx_t = bit_len(q_r.div);
               end
            end
            ADDR_RXD, ADDR_STAT: ;
            default: q_nxt.bresp = RESP_SLVERR;
         endcase
      end
      // Bus read
      if (q_r.rvalid && s_axi_rready)
      begin
         q_nxt.rvalid = 1'b0;
         q_nxt.arready = 1'b1;
      end
      if (s_axi_arvalid && q_r.arready)
      begin
         q_nxt.arready = 1'b0;
         q_nxt.rvalid = 1'b1;
         q_nxt.rresp = RESP_OKAY;
         q_nxt.rdata = '0;
         case (s_axi_araddr)
            ADDR_CTRL: q_nxt.rdata[7:0] = {q_r.pwr, q_r.txe, q_r.rxe, q_r.par, q_r.cl, q_r.sl, 1'b0} | CTRL_FIXED;
            ADDR_BRG: q_nxt.rdata[7:0] = {1'b0, q_r.sel, q_r.div};
            ADDR_TXD: ;
            ADDR_RXD:
            begin
               q_nxt.rdata[7:0] = q_r.rxb;
               q_nxt.rx_full = 1'b0;
            end
            ADDR_STAT:
            begin
               q_nxt.rdata[STAT_OVR] = q_r.e_ovr;
               q_nxt.rdata[STAT_FRM] = q_r.e_frm;
               q_nxt.rdata[STAT_PAR] = q_r.e_par;
               q_nxt.rdata[STAT_RDY] = q_r.rx_full;
               q_nxt.rdata[STAT_BUSY] = (q_r.tx_st != TX_IDLE);
               // Clear on read; a new error below still sets
               q_nxt.e_ovr = 1'b0;
               q_nxt.e_frm = 1'b0;
               q_nxt.e_par = 1'b0;
            end
            default: q_nxt.rresp = RESP_SLVERR;
         endcase
      end
      // Enable synchronisers, clocked by base ticks only
      if (tick)
      begin
         q_nxt.txe_m = q_r.txe;
         q_nxt.txe_s = q_r.txe_m;
         q_nxt.rxe_m = q_r.rxe;
         q_nxt.rxe_s = q_r.rxe_m;
      end
      // ----------------------------------------
      // Transmitter
      // ----------------------------------------
      if (tick && q_r.tx_st != TX_IDLE)
      begin
         if (q_r.tx_t > 5'h01)
         begin
            q_nxt.tx_t = 5'(q_r.tx_t - 5'h01);
         end
         else
         begin
            q_nxt.tx_t = bit_len(q_r.div);
            case (q_r.tx_st)
               TX_START, TX_DATA:
               begin
                  if (q_r.tx_st == TX_START || q_r.tx_n < data_bits(q_r.cl))
                  begin
                     q_nxt.tx_st = TX_DATA;
                     q_nxt.tx_out = q_r.txs[0];
                     q_nxt.tx_p = (q_r.tx_st == TX_START) ? q_r.txs[0] : q_r.tx_p ^ q_r.txs[0];
                     q_nxt.txs = {1'b1, q_r.txs[7:1]};
                     q_nxt.tx_n = (q_r.tx_st == TX_START) ? 4'h1 : 4'(q_r.tx_n + 4'h1);
                  end
                  else if (q_r.par != PAR_NONE)
                  begin
                     q_nxt.tx_st = TX_PAR;
                     q_nxt.tx_out = (q_r.par == PAR_ZERO) ? 1'b0 : q_r.tx_p ^ (q_r.par == PAR_ODD);
                  end
                  else
                  begin
                     q_nxt.tx_st = TX_STOP;
                     q_nxt.tx_out = 1'b1;
                     q_nxt.tx_n = 4'h0;
                  end
               end
               TX_PAR:
               begin
                  q_nxt.tx_st = TX_STOP;
                  q_nxt.tx_out = 1'b1;
                  q_nxt.tx_n = 4'h0;
               end
               TX_STOP:
               begin
                  if (q_r.sl && q_r.tx_n == 4'h0)
                  begin
                     q_nxt.tx_n = 4'h1;
                  end
                  else
                  begin
                     q_nxt.tx_st = TX_IDLE;
                  end
               end
               default: q_nxt.tx_st = TX_IDLE;
            endcase
         end
      end
      if (!q_r.txe_s)
      begin
         q_nxt.tx_st = TX_IDLE;
         q_nxt.txs = BYTE_ONES;
         q_nxt.tx_out = 1'b1;
      end
      // ----------------------------------------
      // Receiver
      // ----------------------------------------
      if (tick && q_r.rx_st == RX_IDLE && !rx_line)
      begin
         q_nxt.rx_st = RX_START;
         q_nxt.rx_t = bit_len(q_r.div) >> 1;
         q_nxt.rx_n = 4'h0;
         q_nxt.rx_p = 1'b0;
      end
      else if (tick && q_r.rx_st != RX_IDLE)
      begin
         if (q_r.rx_t > 5'h01)
         begin
            q_nxt.rx_t = 5'(q_r.rx_t - 5'h01);
         end
         else
         begin
            q_nxt.rx_t = bit_len(q_r.div);
            case (q_r.rx_st)
               RX_START: q_nxt.rx_st = rx_line ? RX_IDLE : RX_DATA;
               RX_DATA:
               begin
                  q_nxt.rxs = {rx_line, q_r.rxs[7:1]};
                  q_nxt.rx_p = q_r.rx_p ^ rx_line;
                  q_nxt.rx_n = 4'(q_r.rx_n + 4'h1);
                  if (4'(q_r.rx_n + 4'h1) == data_bits(q_r.cl))
                  begin
                     q_nxt.rx_st = (q_r.par == PAR_NONE) ? RX_STOP : RX_PAR;
                  end
               end
               RX_PAR:
               begin
                  q_nxt.rx_st = RX_STOP;
                  // Zero parity is received but never judged
                  if (q_r.par[1] && ((q_r.rx_p ^ rx_line) != (q_r.par == PAR_ODD)))
                  begin
                     q_nxt.e_par = 1'b1;
                  end
               end
               RX_STOP:
               begin
                  q_nxt.rx_st = RX_IDLE;
                  store_evt = 1'b1;
                  if (!rx_line)
                  begin
                     q_nxt.e_frm = 1'b1;
                  end
                  // Overrun keeps the unread byte
                  if (q_nxt.rx_full)
                  begin
                     q_nxt.e_ovr = 1'b1;
                  end
                  else
                  begin
                     q_nxt.rx_full = 1'b1;
                     q_nxt.rxb = q_r.cl ? q_r.rxs : {1'b0, q_r.rxs[7:1]};
                  end
               end
               default: q_nxt.rx_st = RX_IDLE;
            endcase
         end
      end
      if (!q_r.rxe_s)
      begin
         q_nxt.rx_st = RX_IDLE;
      end
      // Power off clears the enable synchronisers, receive buffer and status
      if (!q_r.pwr)
      begin
         q_nxt.txe_m = 1'b0;
         q_nxt.txe_s = 1'b0;
         q_nxt.rxe_m = 1'b0;
         q_nxt.rxe_s = 1'b0;
         q_nxt.rxb = BYTE_ONES;
         q_nxt.rx_full = 1'b0;
         q_nxt.e_ovr = 1'b0;
         q_nxt.e_frm = 1'b0;
         q_nxt.e_par = 1'b0;
      end
      q_nxt.awready = !q_nxt.aw_ok && !q_nxt.bvalid;
      q_nxt.wready = !q_nxt.w_ok && !q_nxt.bvalid;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q_r <= '0;
         q_r.div <= DIV_RESET;
         q_r.tx_st <= TX_IDLE;
         q_r.rx_st <= RX_IDLE;
         q_r.txs <= BYTE_ONES;
         q_r.rxb <= BYTE_ONES;
         q_r.tx_out <= 1'b1;
         q_r.awready <= 1'b1;
         q_r.wready <= 1'b1;
         q_r.arready <= 1'b1;
      end
      else if (ce)
      begin
         q_r <= q_nxt;
      end
   end

   assign s_axi_awready = q_r.awready;
   assign s_axi_wready = q_r.wready;
   assign s_axi_bresp = q_r.bresp;
   assign s_axi_bvalid = q_r.bvalid;
   assign s_axi_arready = q_r.arready;
   assign s_axi_rdata = q_r.rdata;
   assign s_axi_rresp = q_r.rresp;
   assign s_axi_rvalid = q_r.rvalid;
   assign serial_out_pin = q_r.tx_out;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   pwr_off_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !q_r.pwr |=> q_r.rxb == BYTE_ONES && !q_r.e_ovr && !q_r.e_frm && !q_r.e_par && !q_r.txe_s)
      else $error("power off did not clear the engine");
   start_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
      q_r.tx_st == TX_START |-> !serial_out_pin)
      else $error("start bit not low");
   stop_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      q_r.tx_st == TX_STOP || q_r.tx_st == TX_IDLE |-> serial_out_pin)
      else $error("stop or idle line not high");
   seven_bit_msb_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && store_evt && !q_r.cl && !q_nxt.e_ovr |=> !q_r.rxb[7] && q_r.rx_full)
      else $error("seven-bit byte has bit seven set");
   en_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(q_r.txe_s) && $past(q_r.pwr) |-> $past(tick))
      else $error("transmit enable moved off a base tick");
   clock_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ce |=> $stable(q_r) && $stable(serial_out_pin))
      else $error("state moved while clock enable low");
   tx_disable_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !q_r.txe_s |=> q_r.tx_st == TX_IDLE && q_r.txs == BYTE_ONES)
      else $error("disabled transmitter not held idle");
   zero_parity_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && tick && q_r.tx_st == TX_DATA && q_r.tx_t == 5'h01 && q_r.tx_n == data_bits(q_r.cl)
      && q_r.par == PAR_ZERO |=> q_r.tx_st == TX_PAR && !serial_out_pin)
      else $error("zero parity bit not low");
   tx_frame_c: cover property (@(posedge aclk) q_r.tx_st == TX_STOP ##1 q_r.tx_st == TX_IDLE);
   rx_store_c: cover property (@(posedge aclk) ce && store_evt && !q_nxt.e_ovr);
   overrun_c: cover property (@(posedge aclk) q_r.e_ovr);
endmodule : asp_port

// ===== asp_pkg.sv
// Shared constants, register map and state codes for the async serial port.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
package asp_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BRG = 8'h04;
   localparam logic [7:0] ADDR_TXD = 8'h08;
   localparam logic [7:0] ADDR_RXD = 8'h0C;
   localparam logic [7:0] ADDR_STAT = 8'h10;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int CTRL_PWR = 7;
   localparam int CTRL_TXE = 6;
   localparam int CTRL_RXE = 5;
   localparam int CTRL_PAR_LO = 3;
   localparam int CTRL_CL = 2;
   localparam int CTRL_SL = 1;
   localparam int BRG_SEL_LO = 5;
   localparam int STAT_OVR = 0;
   localparam int STAT_FRM = 1;
   localparam int STAT_PAR = 2;
   localparam int STAT_RDY = 3;
   localparam int STAT_BUSY = 4;
   localparam logic [7:0] CTRL_FIXED = 8'h01;
   localparam logic [4:0] DIV_RESET = 5'h10;
   localparam logic [4:0] DIV_MIN = 5'h02;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [3:0] DBITS_7 = 4'h7;
   localparam logic [3:0] DBITS_8 = 4'h8;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // State codes
   // ----------------------------------------
   typedef enum logic [4:0] {TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
      TX_PAR = 5'h08, TX_STOP = 5'h10} asp_tx_t;
   typedef enum logic [4:0] {RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
      RX_PAR = 5'h08, RX_STOP = 5'h10} asp_rx_t;
endpackage : asp_pkg

// ===== asp_brg_if.sv
// Link between the port core and its base clock source.
// Assumes both ends run on the same aclk.
`timescale 1ns/10ps
interface asp_brg_if;
   logic run;
   logic [1:0] sel;
   logic base_tick;
   modport gen (input run, input sel, output base_tick);
   modport user (output run, output sel, input base_tick);
endinterface : asp_brg_if

// ===== asp_brg.sv
// Base clock source: one of four prescaled aclk rates, as a one-cycle tick.
// Assumes aclk at 100 MHz and a synchronous active-low reset.
`timescale 1ns/10ps
module asp_brg
   import asp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   asp_brg_if.gen brg
);
   typedef struct packed {
      logic [2:0] pre;
      logic tick;
   } asp_brg_st_t;
   asp_brg_st_t q_r;
   asp_brg_st_t q_nxt;
   logic [2:0] mask;

   // ----------------------------------------
   // Source select: divide by 1, 2, 4 or 8
   // ----------------------------------------
   always_comb
   begin
      q_nxt = q_r;
      mask = 3'((4'h1 << brg.sel) - 4'h1);
      q_nxt.pre = 3'(q_r.pre + 3'h1);
      q_nxt.tick = brg.run && ((q_r.pre & mask) == 3'h0);
      if (!brg.run)
      begin
         q_nxt = '0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q_r <= '0;
      end
      else if (ce)
      begin
         q_r <= q_nxt;
      end
   end

   assign brg.base_tick = q_r.tick && ce;
endmodule : asp_brg

// ===== asp_station.sv
// Remote serial station: sends frames and captures frames on the line.
// Assumes a bit time of B aclk cycles and tasks entered just after a rising edge.
`timescale 1ns/10ps
module asp_station
#(
   parameter int B = 8
)
(
   input wire logic aclk,
   input wire logic line_in,
   output logic line_out
);
   // ----------------------------------------
   // Frame sender
   // ----------------------------------------
   initial line_out = 1'b1;
   task automatic put(input logic [7:0] d, input int n, input logic hp, input logic p);
      int i;
      line_out <= 1'b0;
      repeat (B) @(posedge aclk);
      for (i = 0; i < n; i++)
      begin
         line_out <= d[i];
         repeat (B) @(posedge aclk);
      end
      if (hp)
      begin
         line_out <= p;
         repeat (B) @(posedge aclk);
      end
      line_out <= 1'b1;
      repeat (2 * B) @(posedge aclk);
   endtask : put
   // ----------------------------------------
   // Frame capture
   // ----------------------------------------
   // Sampled on the falling edge, away from the sender's launch edge
   task automatic get(input int n, input logic hp, output logic [7:0] d, output logic p, output logic [1:0] s);
      int i;
      d = 8'h00;
      p = 1'b0;
      @(negedge line_in);
      repeat (B / 2) @(negedge aclk);
      for (i = 0; i < n; i++)
      begin
         repeat (B) @(negedge aclk);
         d[i] = line_in;
      end
      if (hp)
      begin
         repeat (B) @(negedge aclk);
         p = line_in;
      end
      repeat (B) @(negedge aclk);
      s[0] = line_in;
      repeat (B) @(negedge aclk);
      s[1] = line_in;
   endtask : get
endmodule : asp_station

// ===== test_async_serial_port.sv
// Bench for the async serial port: register tasks and frame checks.
// Assumes asp_port at the top, its base clock source inside.
`timescale 1ns/10ps
module test_async_serial_port
   import asp_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, txl, rxl, v;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] c, d, m;
   int failures = 0, check_count = 0, cyc = 0, i;
   always #5 aclk = ~aclk;
   asp_port DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_in_pin(rxl),
      .serial_out_pin(txl));
   asp_station #(.B(8)) st0 (.aclk(aclk), .line_in(txl), .line_out(rxl));
   // ----------------------------------------
   // Checks and bus tasks
   // ----------------------------------------
   task automatic print_verdict();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      check_count++;
      if (g !== e)
      begin
         failures++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] dd, input logic [1:0] er);
      logic aok, wok, bok;
      bok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, dd};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bok)
      begin
         @(negedge aclk);
         aok = (awvalid && awready) === 1'b1;
         wok = (wvalid && wready) === 1'b1;
         bok = bvalid === 1'b1;
         if (bok) chk({32'h00000000, bresp}, {32'h00000000, er});
         @(posedge aclk);
         if (aok) awvalid <= 1'b0;
         if (wok) wvalid <= 1'b0;
         if (bok) bready <= 1'b0;
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      logic aok, rok;
      rok = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rok)
      begin
         @(negedge aclk);
         aok = (arvalid && arready) === 1'b1;
         rok = rvalid === 1'b1;
         if (rok) chk({rresp, (er == RESP_OKAY) ? rdata : 32'h00000000}, {er, 24'h000000, e});
         @(posedge aclk);
         if (aok) arvalid <= 1'b0;
         if (rok) rready <= 1'b0;
      end
   endtask : rd
   // ----------------------------------------
   // Frame tasks
   // ----------------------------------------
   function automatic logic pbit(input logic [7:0] x, input logic [1:0] pm);
      return (pm == 2'h2) ? ~^x : ((pm == 2'h3) ? ^x : 1'b0);
   endfunction : pbit
   task automatic txc(input logic [7:0] dd, input logic [7:0] cf);
      logic [7:0] gd, mm;
      logic gp;
      logic [1:0] gs;
      mm = cf[CTRL_CL] ? dd : {1'b0, dd[6:0]};
      fork
         st0.get(cf[CTRL_CL] ? 8 : 7, cf[4:3] != PAR_NONE, gd, gp, gs);
         wr(ADDR_TXD, dd, RESP_OKAY);
      join
      rd(ADDR_STAT, {3'h0, cf[CTRL_SL], 4'h0}, RESP_OKAY);
      chk({26'h0, gd}, {26'h0, mm});
      chk({33'h0, gp}, {33'h0, pbit(mm, cf[4:3])});
      chk({33'h0, gs[0]}, 34'h1);
   endtask : txc
   task automatic rxc(input logic [7:0] dd, input logic [7:0] cf, input logic bad);
      logic [7:0] mm;
      // Seven-bit frames judge parity over the bits actually sent
      mm = cf[CTRL_CL] ? dd : {1'b0, dd[6:0]};
      st0.put(dd, cf[CTRL_CL] ? 8 : 7, cf[4:3] != PAR_NONE, pbit(mm, cf[4:3]) ^ bad);
   endtask : rxc
   // Hang guard
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         failures++;
         print_verdict();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk({33'h0, txl}, 34'h1);
      rd(ADDR_CTRL, 8'h01, RESP_OKAY);
      rd(ADDR_BRG, 8'h10, RESP_OKAY);
      rd(ADDR_RXD, 8'hFF, RESP_OKAY);
      rd(ADDR_STAT, 8'h00, RESP_OKAY);
      wr(8'h14, 8'h00, RESP_SLVERR);
      rd(8'h14, 8'h00, RESP_SLVERR);
      wr(ADDR_BRG, 8'h08, RESP_OKAY);
      rd(ADDR_BRG, 8'h08, RESP_OKAY);
      for (i = 0; i < 8; i++)
      begin
         c = {3'h7, i[1:0], ~i[2], i[0], 1'b1};
         d = 8'hA5 ^ (8'h3C * i[7:0]);
         m = c[CTRL_CL] ? d : {1'b0, d[6:0]};
         wr(ADDR_CTRL, c & 8'h9F, RESP_OKAY);
         wr(ADDR_CTRL, c, RESP_OKAY);
         repeat (3) @(posedge aclk);
         txc(d, c);
         rxc(d, c, c[4:3] == PAR_ZERO);
         rd(ADDR_STAT, 8'h08, RESP_OKAY);
         rd(ADDR_RXD, m, RESP_OKAY);
      end
      // Parity error, then overrun on a clean byte
      wr(ADDR_CTRL, 8'h95, RESP_OKAY);
      wr(ADDR_CTRL, 8'hF5, RESP_OKAY);
      rxc(8'h3C, 8'hF5, 1'b1);
      rxc(8'hC3, 8'hF5, 1'b0);
      rd(ADDR_STAT, 8'h0D, RESP_OKAY);
      rd(ADDR_STAT, 8'h08, RESP_OKAY);
      rd(ADDR_RXD, 8'h3C, RESP_OKAY);
      // Receiver off while transmitter keeps going
      wr(ADDR_CTRL, 8'hD5, RESP_OKAY);
      rxc(8'h77, 8'hD5, 1'b0);
      rd(ADDR_STAT, 8'h00, RESP_OKAY);
      wr(ADDR_BRG, 8'h24, RESP_OKAY);
      txc(8'h96, 8'hD5);
      wr(ADDR_BRG, 8'h42, RESP_OKAY);
      rd(ADDR_BRG, 8'h42, RESP_OKAY);
      txc(8'h69, 8'hD5);
      // Stopped clock mid-frame holds the pin
      wr(ADDR_TXD, 8'h00, RESP_OKAY);
      repeat (20) @(posedge aclk);
      ce <= 1'b0;
      @(negedge aclk);
      v = txl;
      repeat (16)
      begin
         @(negedge aclk);
         chk({33'h0, txl}, {33'h0, v});
      end
      @(posedge aclk);
      ce <= 1'b1;
      repeat (200) @(posedge aclk);
      rd(ADDR_STAT, 8'h00, RESP_OKAY);
      // Restart after a clock stop: power off, then power before enables
      wr(ADDR_CTRL, 8'h00, RESP_OKAY);
      wr(ADDR_CTRL, 8'h95, RESP_OKAY);
      repeat (16) @(posedge aclk);
      // Power off clears buffer and status
      wr(ADDR_CTRL, 8'hF5, RESP_OKAY);
      repeat (16) @(posedge aclk);
      rxc(8'h5A, 8'hF5, 1'b0);
      rd(ADDR_STAT, 8'h08, RESP_OKAY);
      wr(ADDR_CTRL, 8'h00, RESP_OKAY);
      rd(ADDR_CTRL, 8'h01, RESP_OKAY);
      rd(ADDR_RXD, 8'hFF, RESP_OKAY);
      rd(ADDR_STAT, 8'h00, RESP_OKAY);
      chk({33'h0, txl}, 34'h1);
      print_verdict();
   end
endmodule : test_async_serial_port
